// ===== src/pwm_submodule_pkg.sv
package pwm_submodule_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// register word indices on the plain register port
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_PERIOD         = 4'h1;
	localparam logic [3:0] ADDR_WIDTH          = 4'h2;
	localparam logic [3:0] ADDR_COUNTER        = 4'h3;

	////////////////////////////////////////////////////////////////////////////////
	// field positions in the status/interrupt/control word
	localparam int FLAG_BIT       = 15;
	localparam int IRQ_LEVEL_LSB  = 12;
	localparam int ARB_MSB_BIT    = 11;
	localparam int PIN_LEVEL_BIT  = 6;
	localparam int ENABLE_BIT     = 5;
	localparam int INVERSION_BIT  = 4;
	localparam int LOAD_BIT       = 3;
	localparam int CLOCK_SEL_LSB  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// reset values and counter constants
	localparam logic [15:0] COUNTER_START    = 16'h0001;
	localparam logic [15:0] WIDTH_ZERO       = 16'h0000;
	localparam logic [15:0] USER_RESET_VALUE = 16'h0000;
	localparam logic [2:0]  IRQ_LEVEL_OFF    = 3'h0;
	localparam int          PRESCALE_BITS    = 9;
	localparam int          IRQ_LINES        = 7;

	////////////////////////////////////////////////////////////////////////////////
	// software-written control fields
	typedef struct packed {
		logic [2:0] irqPriorityLevel;
		logic       arbNumberMsb;
		logic       enable;
		logic       outputInversion;
		logic [2:0] clockSel;
	} control_type;

	localparam control_type CONTROL_RESET = '{
		irqPriorityLevel: 3'h0,
		arbNumberMsb:     1'b0,
		enable:           1'b0,
		outputInversion:  1'b0,
		clockSel:         3'h0
	};

	// interrupt acknowledge cycle from the processor
	typedef struct packed {
		logic       valid;
		logic [2:0] maskLevel;
	} iack_type;

endpackage

// ===== src/pwm_submodule_status_control.sv
`timescale 1ns/1ns

module pwm_submodule_status_control (
	input  wire logic                              clock,
	input  wire logic                              reset_n,
	input  wire logic [3:0]                        regAddr,
	input  wire logic [15:0]                       regWriteData,
	input  wire logic                              regWrite,
	input  wire logic                              regRead,
	output logic      [15:0]                       regReadData,
	input  wire logic [2:0]                        arbNumberLow,
	input  wire pwm_submodule_pkg::iack_type       iack,
	output logic      [pwm_submodule_pkg::IRQ_LINES:1] irqRequest,
	output logic                                   iackRespond,
	output logic      [3:0]                        arbNumber,
	output logic                                   pwmPin
);

	////////////////////////////////////////////////////////////////////////////////
	// state
	// software copies, hidden buffers and the running waveform
	pwm_submodule_pkg::control_type ctrl_q;
	logic [15:0] periodUserValue_q;
	logic [15:0] widthUserValue_q;
	logic [15:0] periodBuffer_q;
	logic [15:0] widthBuffer_q;
	logic [15:0] waveformCounter_q;
	logic [15:0] waveformCounter_d;
	logic [pwm_submodule_pkg::PRESCALE_BITS-1:0] prescale_q;
	logic        outFlop_q;
	logic        outFlop_d;
	logic        flag_q;
	logic        flag_d;
	logic        clearArmed_q;
	logic        clearArmed_d;
	logic        enabledLast_q;

	typedef enum {SEQ_IDLE, SEQ_RUN} seq_type;
	seq_type seq_q;
	seq_type seq_d;

	////////////////////////////////////////////////////////////////////////////////
	// decoding helpers

	// prescaler tap mask for each clock-select code
	function automatic logic [pwm_submodule_pkg::PRESCALE_BITS-1:0] tapMask(
		input logic [2:0] sel
	);
		logic [pwm_submodule_pkg::PRESCALE_BITS-1:0] m;
		m = '0;
		case (sel)
			3'h0: m = 9'h001;
			3'h1: m = 9'h003;
			3'h2: m = 9'h007;
			3'h3: m = 9'h00f;
			3'h4: m = 9'h01f;
			3'h5: m = 9'h03f;
			3'h6: m = 9'h07f;
			3'h7: m = 9'h1ff;
			default: m = 9'h001;
		endcase
		return m;
	endfunction

	// one-hot request line for a priority level, zero gives none
	function automatic logic [pwm_submodule_pkg::IRQ_LINES:1] levelLine(
		input logic [2:0] lvl
	);
		logic [pwm_submodule_pkg::IRQ_LINES:1] l;
		l = '0;
		for (int i = 1; i <= pwm_submodule_pkg::IRQ_LINES; i++) begin
			if (lvl == 3'(i)) begin
				l[i] = 1'b1;
			end
		end
		return l;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// register port decode
	// reads and writes are single-cycle strobes; the slave never stalls
	// counter and unmapped indices take no write
	wire selStatus  = (regAddr == pwm_submodule_pkg::ADDR_STATUS_CONTROL);
	wire selPeriod  = (regAddr == pwm_submodule_pkg::ADDR_PERIOD);
	wire selWidth   = (regAddr == pwm_submodule_pkg::ADDR_WIDTH);
	wire selCounter = (regAddr == pwm_submodule_pkg::ADDR_COUNTER);
	wire wrStatus   = regWrite && selStatus;
	wire rdStatus   = regRead && selStatus;

	// incoming control fields from a status word write
	// the flag, pin and load bits are not part of the stored control word
	pwm_submodule_pkg::control_type ctrlWrite;
	assign ctrlWrite.irqPriorityLevel = regWriteData[pwm_submodule_pkg::IRQ_LEVEL_LSB +: 3];
	assign ctrlWrite.arbNumberMsb     = regWriteData[pwm_submodule_pkg::ARB_MSB_BIT];
	assign ctrlWrite.enable           = regWriteData[pwm_submodule_pkg::ENABLE_BIT];
	assign ctrlWrite.outputInversion  = regWriteData[pwm_submodule_pkg::INVERSION_BIT];
	assign ctrlWrite.clockSel         = regWriteData[pwm_submodule_pkg::CLOCK_SEL_LSB +: 3];

	////////////////////////////////////////////////////////////////////////////////
	// waveform timing terms
	// a load only counts while already enabled, so a write that enables
	// and loads at once is treated as a plain enable
	// the prescaler advances every enabled cycle except a load; the counter moves on a full tap
	wire enabled      = ctrl_q.enable;
	wire enableRise   = enabled && !enabledLast_q;
	wire loadStrobe   = wrStatus && regWriteData[pwm_submodule_pkg::LOAD_BIT] && enabled;
	wire [pwm_submodule_pkg::PRESCALE_BITS-1:0] mask = tapMask(ctrl_q.clockSel);
	wire countTick    = enabled && ((prescale_q & mask) == mask);
	wire periodMatch  = (waveformCounter_q == periodBuffer_q);
	wire widthMatch   = (waveformCounter_q == widthBuffer_q);
	wire periodEnd    = countTick && (seq_q == SEQ_RUN) && periodMatch;
	wire restart      = loadStrobe || periodEnd;

	// buffer values taken at a restart, latest user write included
	// a user write in the same cycle as a restart is not lost
	wire [15:0] nextPeriod = (regWrite && selPeriod) ? regWriteData : periodUserValue_q;
	wire [15:0] nextWidth  = (regWrite && selWidth) ? regWriteData : widthUserValue_q;

	////////////////////////////////////////////////////////////////////////////////
	// sequencer next state
	// idle while disabled, running otherwise; a load restarts it
	// a period end is only honoured in the running state
	always_comb begin
		seq_d = seq_q;
		case (seq_q)
			SEQ_IDLE: begin
				if (enabled) begin
					seq_d = SEQ_RUN;
				end
			end
			SEQ_RUN: begin
				if (!enabled) begin
					seq_d = SEQ_IDLE;
				end
			end
			default: seq_d = SEQ_IDLE;
		endcase
		if (loadStrobe) begin
			seq_d = SEQ_RUN;
		end
	end

	// counter and output flop next values
	// disable wins over load, load over the enable edge, and a period end
	// over a width match, so the output never toggles twice in a cycle
	always_comb begin
		waveformCounter_d = waveformCounter_q;
		outFlop_d = outFlop_q;
		if (!enabled) begin
			waveformCounter_d = pwm_submodule_pkg::COUNTER_START;
			outFlop_d = 1'b0;
		end else if (loadStrobe) begin
			waveformCounter_d = pwm_submodule_pkg::COUNTER_START;
			outFlop_d = (nextWidth != pwm_submodule_pkg::WIDTH_ZERO);
		end else if (enableRise) begin
			outFlop_d = 1'b1;
		end else if (periodEnd) begin
			waveformCounter_d = pwm_submodule_pkg::COUNTER_START;
			outFlop_d = (nextWidth != pwm_submodule_pkg::WIDTH_ZERO);
		end else if (countTick) begin
			if (widthMatch) begin
				outFlop_d = 1'b0;
			end
			waveformCounter_d = waveformCounter_q + 16'h0001;
		end
	end

	// completion flag: set wins over the software clear
	// a clear needs a status read that saw the flag, then a status write
	// with the flag bit low; any status write drops the arming
	// disabling the block forces the flag and the arming low
	wire flagEvent  = enableRise || periodEnd || loadStrobe;
	wire flagClear  = wrStatus && clearArmed_q
		&& !regWriteData[pwm_submodule_pkg::FLAG_BIT];
	always_comb begin
		flag_d = flag_q;
		clearArmed_d = clearArmed_q;
		if (flagClear) begin
			flag_d = 1'b0;
		end
		if (wrStatus) begin
			clearArmed_d = 1'b0;
		end
		if (rdStatus && flag_q) begin
			clearArmed_d = 1'b1;
		end
		if (flagEvent) begin
			flag_d = 1'b1;
		end
		if (!enabled) begin
			flag_d = 1'b0;
			clearArmed_d = 1'b0;
		end
	end

	// pin level: disabled follows polarity, enabled true or inverted flop
	// the pin lags the output flop by one cycle
	wire pinNext = ctrl_q.enable ? (outFlop_q ^ ctrl_q.outputInversion)
		: ctrl_q.outputInversion;

	////////////////////////////////////////////////////////////////////////////////
	// interrupt terms
	// request and acknowledge follow the flag one cycle later
	// the acknowledge answers only at the exact programmed level
	wire irqActive = flag_q && (ctrl_q.irqPriorityLevel != pwm_submodule_pkg::IRQ_LEVEL_OFF);
	wire [pwm_submodule_pkg::IRQ_LINES:1] irqNext = irqActive
		? levelLine(ctrl_q.irqPriorityLevel) : '0;
	wire iackMatch = iack.valid && irqActive
		&& (iack.maskLevel == ctrl_q.irqPriorityLevel);
	wire [3:0] arbNext = {ctrl_q.arbNumberMsb, arbNumberLow};

	////////////////////////////////////////////////////////////////////////////////
	// read data selection
	// read data stand for one cycle after the strobe, zero otherwise
	wire [15:0] statusWord = {
		flag_q,
		ctrl_q.irqPriorityLevel,
		ctrl_q.arbNumberMsb,
		4'h0,
		pwmPin,
		ctrl_q.enable,
		ctrl_q.outputInversion,
		1'b0,
		ctrl_q.clockSel
	};
	wire [15:0] readNext = selStatus  ? statusWord
		: selPeriod  ? periodUserValue_q
		: selWidth   ? widthUserValue_q
		: selCounter ? waveformCounter_q
		: 16'h0000;

	////////////////////////////////////////////////////////////////////////////////
	// software registers; the pin status bit takes no write
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q <= pwm_submodule_pkg::CONTROL_RESET;
		end else if (wrStatus) begin
			ctrl_q <= ctrlWrite;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			periodUserValue_q <= pwm_submodule_pkg::USER_RESET_VALUE;
			widthUserValue_q  <= pwm_submodule_pkg::USER_RESET_VALUE;
		end else begin
			periodUserValue_q <= nextPeriod;
			widthUserValue_q  <= nextWidth;
		end
	end

	// hidden buffers: follow user values when disabled, else at restart
	// while running, a new period or width waits for the next restart
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			periodBuffer_q <= pwm_submodule_pkg::USER_RESET_VALUE;
			widthBuffer_q  <= pwm_submodule_pkg::USER_RESET_VALUE;
		end else if (!enabled || restart) begin
			periodBuffer_q <= nextPeriod;
			widthBuffer_q  <= nextWidth;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// prescaler, held in reset while disabled or on reload
	// clearing it on a load gives a full first tick after the restart
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			prescale_q <= '0;
		end else if (!enabled || loadStrobe) begin
			prescale_q <= '0;
		end else begin
			prescale_q <= prescale_q + 9'h001;
		end
	end

	// counter, output flop and sequencer
	// the enable history feeds the edge detector for the flag and output
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			waveformCounter_q <= pwm_submodule_pkg::COUNTER_START;
			outFlop_q         <= 1'b0;
			seq_q             <= SEQ_IDLE;
			enabledLast_q     <= 1'b0;
		end else begin
			waveformCounter_q <= waveformCounter_d;
			outFlop_q         <= outFlop_d;
			seq_q             <= seq_d;
			enabledLast_q     <= enabled;
		end
	end

	// completion flag and its clear handshake
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			flag_q       <= 1'b0;
			clearArmed_q <= 1'b0;
		end else begin
			flag_q       <= flag_d;
			clearArmed_q <= clearArmed_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registered outputs
	// every port leaves from a flip-flop
	// unread cycles return zero on the read data
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pwmPin      <= 1'b0;
			irqRequest  <= '0;
			iackRespond <= 1'b0;
			arbNumber   <= 4'h0;
			regReadData <= 16'h0000;
		end else begin
			pwmPin      <= pinNext;
			irqRequest  <= irqNext;
			iackRespond <= iackMatch;
			arbNumber   <= arbNext;
			regReadData <= regRead ? readNext : 16'h0000;
		end
	end

endmodule

// ===== dv/pwm_status_chk.sv
`timescale 1ns/1ns
module pwm_status_chk (
	input wire logic                                  clock,
	input wire logic                                  reset_n,
	input wire logic [3:0]                            regAddr,
	input wire logic [15:0]                           regWriteData,
	input wire logic                                  regWrite,
	input wire logic                                  regRead,
	input wire logic [15:0]                           regReadData,
	input wire logic [2:0]                            arbNumberLow,
	input wire pwm_submodule_pkg::iack_type           iack,
	input wire logic [pwm_submodule_pkg::IRQ_LINES:1] irqRequest,
	input wire logic                                  iackRespond,
	input wire logic [3:0]                            arbNumber,
	input wire logic                                  pwmPin
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	////////////////////////////////////////////////////////////
	// register port steps on the status word
	sequence rdStat; regRead && regAddr == 4'h0; endsequence
	sequence wrOff; regWrite && regAddr == 4'h0 && !regWriteData[5]; endsequence
	sequence offIdle; wrOff ##1 !regWrite; endsequence
	sequence wrLoad; regWrite && regAddr == 4'h0 && regWriteData[5] && regWriteData[3]; endsequence
	////////////////////////////////////////////////////////////
	a_load_reads_zero: assert property (rdStat |=> regReadData[3] == 1'b0)
		else $error("load bit read as one");
	a_pin_readback: assert property (rdStat |=> regReadData[6] == $past(pwmPin))
		else $error("pin bit differs from pin");
	a_off_flag_clear: assert property (offIdle ##1 rdStat |=> !regReadData[15])
		else $error("flag set while disabled");
	a_load_sets_flag: assert property (wrLoad ##1 !regWrite ##1 rdStat |=> regReadData[15])
		else $error("flag not set by enable or load");
	a_off_counter: assert property (offIdle ##1 (regRead && regAddr == 4'h3) |=> regReadData == 16'h0001)
		else $error("counter not held at one");
	a_off_pin: assert property (wrOff ##1 !regWrite [*3] |=> pwmPin == $past(regWriteData[4], 4))
		else $error("disabled pin not at polarity");
	a_irq_one_line: assert property ($onehot0(irqRequest))
		else $error("several request lines");
	a_ack_level: assert property (iackRespond |-> $past(iack.valid) && irqRequest[$past(iack.maskLevel)])
		else $error("acknowledge answered at wrong level");
	a_arb_low: assert property (1'b1 |=> arbNumber[2:0] == $past(arbNumberLow))
		else $error("arbitration low bits wrong");
endmodule

// ===== dv/pwm_partner.sv
`timescale 1ns/1ns
module pwm_partner (
	input  wire logic                                  clock,
	input  wire logic                                  reset_n,
	input  wire logic                                  pwmPin,
	input  wire logic [pwm_submodule_pkg::IRQ_LINES:1] irqRequest,
	output pwm_submodule_pkg::iack_type                iack,
	output int                                         rises,
	output int                                         highLen,
	output int                                         periodLen
);
	int   highCnt = 0;
	int   periodCnt = 0;
	int   gap = 0;
	logic lastPin = 1'b0;
	////////////////////////////////////////////////////////////
	// processor: acknowledges the highest pending line, then backs off
	always @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			iack <= '0;
			gap <= 0;
		end else if (irqRequest != '0 && gap == 0) begin
			iack.valid <= 1'b1;
			for (int i = 1; i <= 7; i++) begin
				if (irqRequest[i]) iack.maskLevel <= 3'(i);
			end
			gap <= 20;
		end else begin
			iack.valid <= 1'b0;
			iack.maskLevel <= ~iack.maskLevel; // idle mask lines flip to their complement every cycle
			gap <= (gap > 0) ? gap - 1 : 0;
		end
	end
	// pin watcher: last high pulse and last whole period in cycles
	always @(posedge clock) begin
		lastPin <= pwmPin;
		highCnt <= pwmPin ? highCnt + 1 : 0;
		periodCnt <= periodCnt + 1;
		if (!reset_n) begin
			rises <= 0;
		end else if (pwmPin && !lastPin) begin
			rises <= rises + 1;
			periodLen <= periodCnt;
			periodCnt <= 1;
		end
		if (!pwmPin && lastPin) highLen <= highCnt;
	end
endmodule

// ===== dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic                                  clock;
	logic                                  reset_n;
	logic [3:0]                            regAddr;
	logic [15:0]                           regWriteData;
	logic                                  regWrite;
	logic                                  regRead;
	logic [15:0]                           regReadData;
	logic [2:0]                            arbNumberLow;
	pwm_submodule_pkg::iack_type           iack;
	logic [pwm_submodule_pkg::IRQ_LINES:1] irqRequest;
	logic                                  iackRespond;
	logic [3:0]                            arbNumber;
	logic                                  pwmPin;
	int                                    rises;
	int                                    highLen;
	int                                    periodLen;
	int                                    n_fail = 0;
	int                                    n_tests = 0;
	logic [15:0]                           d;
	////////////////////////////////////////////////////////////
	pwm_submodule_status_control pwm_submodule_status_control_i (
		.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
		.arbNumberLow(arbNumberLow), .iack(iack), .irqRequest(irqRequest),
		.iackRespond(iackRespond), .arbNumber(arbNumber), .pwmPin(pwmPin));
	pwm_partner pwm_partner_i (
		.clock(clock), .reset_n(reset_n), .pwmPin(pwmPin), .irqRequest(irqRequest),
		.iack(iack), .rises(rises), .highLen(highLen), .periodLen(periodLen));
	////////////////////////////////////////////////////////////
	// register port and comparison helpers
	task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
		n_tests++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		regAddr <= a;
		regWriteData <= v;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		d = regReadData;
	endtask
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset;
		wr(4'h3, 16'h1234);
		wr(4'h9, 16'hffff);
		rd(4'h0);
		chk("status", d, 16'h0000);
		rd(4'h3);
		chk("counter", d, 16'h0001);
		rd(4'h9);
		chk("unmapped", d, 16'h0000);
		$display("reset done");
	endtask
	task automatic t_disabled;
		wr(4'h0, 16'h0018);
		rd(4'h0);
		chk("status", d, 16'h0050);
		chk("pin", 16'(pwmPin), 16'h0001);
		wr(4'h0, 16'h0000);
		$display("disabled done");
	endtask
	task automatic t_wave;
		int n;
		arbNumberLow <= 3'h5;
		n = rises;
		wr(4'h1, 16'h0100);
		wr(4'h2, 16'h0040);
		wr(4'h0, 16'h5820);
		rd(4'h0);
		chk("status", d & 16'hffbf, 16'hd820);
		chk("irq line", 16'(irqRequest), 16'h0010);
		chk("arb number", 16'(arbNumber), 16'h000d);
		for (int i = 0; i < 40 && !iackRespond; i++) idle(1);
		chk("ack", 16'(iackRespond), 16'h0001);
		// first period after enabling is a cycle short; judge the second one
		for (int i = 0; i < 3000 && rises < n + 3; i++) idle(1);
		chk("high", 16'(highLen), 16'h0080);
		chk("period", 16'(periodLen), 16'h0200);
		$display("wave done");
	endtask
	task automatic t_flag;
		rd(4'h0);
		chk("flag", 16'(d[15]), 16'h0001);
		wr(4'h0, 16'h5820);
		rd(4'h0);
		chk("flag", 16'(d[15]), 16'h0000);
		wr(4'h0, 16'hd820);
		rd(4'h0);
		chk("flag", 16'(d[15]), 16'h0000);
		chk("irq line", 16'(irqRequest), 16'h0000);
		for (int i = 0; i < 700 && irqRequest == '0; i++) idle(1);
		rd(4'h0);
		chk("flag", 16'(d[15]), 16'h0001);
		$display("flag done");
	endtask
	task automatic t_reload;
		int n;
		wr(4'h2, 16'h0000);
		rd(4'h0);
		wr(4'h0, 16'h5828);
		rd(4'h0);
		chk("flag", 16'(d[15]), 16'h0001);
		n = rises;
		idle(1100);
		chk("no pulse", 16'(rises - n), 16'h0000);
		wr(4'h2, 16'h0010);
		wr(4'h0, 16'h5828);
		rd(4'h3);
		chk("counter", 16'(d < 16'h0004), 16'h0001);
		chk("pin", 16'(pwmPin), 16'h0001);
		$display("reload done");
	endtask
	task automatic t_clksel;
		int n;
		n = rises;
		wr(4'h0, 16'h5821);
		for (int i = 0; i < 4000 && rises < n + 2; i++) idle(1);
		chk("period", 16'(periodLen), 16'h0400);
		chk("high", 16'(highLen), 16'h0040);
		$display("clock select done");
	endtask
	task automatic t_off;
		wr(4'h0, 16'h0010);
		rd(4'h3);
		chk("counter", d, 16'h0001);
		rd(4'h0);
		chk("status", d & 16'hffbf, 16'h0010);
		chk("pin", 16'(pwmPin), 16'h0001);
		chk("irq line", 16'(irqRequest), 16'h0000);
		$display("off done");
	endtask
	////////////////////////////////////////////////////////////
	// clock, main sequence and watchdog
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		reset_n = 1'b0;
		regAddr = 4'h0;
		regWriteData = 16'h0000;
		regWrite = 1'b0;
		regRead = 1'b0;
		arbNumberLow = 3'h0;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		t_reset();
		t_disabled();
		t_wave();
		t_flag();
		t_reload();
		t_clksel();
		t_off();
		finish_test();
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		finish_test();
	end
endmodule
bind pwm_submodule_status_control pwm_status_chk pwm_status_chk_i (
	.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
	.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
	.arbNumberLow(arbNumberLow), .iack(iack), .irqRequest(irqRequest),
	.iackRespond(iackRespond), .arbNumber(arbNumber), .pwmPin(pwmPin));
